//--- logic/tpb_timer.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module tpb_timer #(
	parameter int TMR_W = 10,
	parameter int PRE_W = 8
) (
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_reset,
	input  wire logic [tpb_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [tpb_pkg::DATA_W-1:0]  i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [tpb_pkg::DATA_W-1:0]  o_rdata,
	input  wire logic                        i_ext_clock_pin,
	output logic                             o_pwm_port_pin,
	output logic                             o_pwm_pin_enable,
	output logic                             o_buzzer,
	output logic                             o_timer_flag
);

	// Widths fixed by the register map
	if (TMR_W != 10 || PRE_W != 8) begin : g_bad_width
		$error("tpb_timer supports only a 10-bit timer and 8-bit prescaler");
	end

	logic [7:0]       reload_low_r;
	logic [7:0]       control_one_r;
	logic [7:0]       control_two_r;
	logic [7:0]       duty_low_r;
	logic [7:0]       buzzer_control_r;
	logic [7:0]       shared_high_r;
	logic [PRE_W-1:0] prescaler_r;
	logic [TMR_W-1:0] count_r;
	logic             oneshot_done_r;
	logic             ext_prev_r;
	logic             flag_r;

	logic             wr_count;
	logic             run_enable;
	logic             auto_reload;
	logic             one_shot;
	logic             pwm_active_low;
	logic             prescaler_enable_n;
	logic [2:0]       prescale_ratio_select;
	logic             ext_clock_edge_select;
	logic             clock_source_select;
	logic [3:0]       buzzer_frequency_select;
	logic             buzzer_enable;
	logic [TMR_W-1:0] reload_value;
	logic [TMR_W-1:0] duty_value;
	logic             ext_rise;
	logic             ext_fall;
	logic             src_tick;
	logic [PRE_W-1:0] pre_mask;
	logic             pre_tick;
	logic             timer_tick;
	logic             underflow;
	logic             pwm_level;
	logic             buzz_src;

	// Field views of the control registers
	assign run_enable              = control_one_r[tpb_pkg::BIT_RUN_ENABLE];
	assign auto_reload             = control_one_r[tpb_pkg::BIT_AUTO_RELOAD];
	assign one_shot                = control_one_r[tpb_pkg::BIT_ONE_SHOT];
	assign pwm_active_low          = control_one_r[tpb_pkg::BIT_PWM_ACTIVE_LOW];
	assign prescale_ratio_select   = control_two_r[tpb_pkg::BIT_PRESCALE_LSB +: 3];
	assign prescaler_enable_n      = control_two_r[tpb_pkg::BIT_PRESCALER_EN_N];
	assign ext_clock_edge_select   = control_two_r[tpb_pkg::BIT_EDGE_SELECT];
	assign clock_source_select     = control_two_r[tpb_pkg::BIT_CLOCK_SOURCE];
	assign buzzer_frequency_select = buzzer_control_r[tpb_pkg::BIT_BUZZ_FREQ_LSB +: 4];
	assign buzzer_enable           = buzzer_control_r[tpb_pkg::BIT_BUZZ_ENABLE];
	assign wr_count                = i_wr && (i_addr == tpb_pkg::OFS_COUNT_RELOAD);

	// Ten-bit reload and duty values
	assign reload_value = {shared_high_r[tpb_pkg::BIT_RELOAD_HIGH_LSB +: 2], reload_low_r};
	assign duty_value   = {shared_high_r[tpb_pkg::BIT_DUTY_HIGH_LSB +: 2], duty_low_r};

	// Register writes
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			reload_low_r     <= tpb_pkg::RST_BYTE;
			control_one_r    <= tpb_pkg::RST_CONTROL_ONE;
			control_two_r    <= tpb_pkg::RST_CONTROL_TWO;
			duty_low_r       <= tpb_pkg::RST_BYTE;
			buzzer_control_r <= tpb_pkg::RST_BUZZER_CONTROL;
			shared_high_r    <= tpb_pkg::RST_BYTE;
		end else if (i_wr) begin
			case (i_addr)
				tpb_pkg::OFS_COUNT_RELOAD:   reload_low_r     <= i_wdata;
				tpb_pkg::OFS_CONTROL_ONE:    control_one_r    <= i_wdata & 8'hC7;
				tpb_pkg::OFS_CONTROL_TWO:    control_two_r    <= i_wdata & 8'h3F;
				tpb_pkg::OFS_DUTY_LOW:       duty_low_r       <= i_wdata;
				tpb_pkg::OFS_BUZZER_CONTROL: buzzer_control_r <= i_wdata & 8'h8F;
				tpb_pkg::OFS_SHARED_HIGH:    shared_high_r    <= i_wdata;
				default: ;
			endcase
		end
	end

	// External pin edge history
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= i_ext_clock_pin;
		end
	end

	assign ext_rise = i_ext_clock_pin && !ext_prev_r;
	assign ext_fall = !i_ext_clock_pin && ext_prev_r;

	// Source tick: every instruction clock or the chosen pin edge
	always_comb begin
		if (clock_source_select) begin
			src_tick = ext_clock_edge_select ? ext_fall : ext_rise;
		end else begin
			src_tick = 1'b1;
		end
	end

	// Prescaler mask of the low select+1 bits
	assign pre_mask = PRE_W'((16'h0002 << prescale_ratio_select) - 16'h0001);

	// Prescaler down-counter, runs only while enabled
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			prescaler_r <= tpb_pkg::RST_PRESCALER;
		end else if (!prescaler_enable_n && src_tick) begin
			prescaler_r <= prescaler_r - tpb_pkg::PRE_ONE;
		end
	end

	// Divided tick on wrap of the selected low bits, or raw when bypassed
	assign pre_tick   = src_tick && ((prescaler_r & pre_mask) == '0);
	assign timer_tick = run_enable && (prescaler_enable_n ? src_tick : pre_tick);
	assign underflow  = timer_tick && (count_r == tpb_pkg::COUNT_ZERO) && !oneshot_done_r;

	// Timer counter
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			count_r <= tpb_pkg::RST_COUNT;
		end else if (wr_count) begin
			count_r <= {shared_high_r[tpb_pkg::BIT_RELOAD_HIGH_LSB +: 2], i_wdata};
		end else if (underflow) begin
			if (one_shot) begin
				count_r <= tpb_pkg::COUNT_ZERO;
			end else if (auto_reload) begin
				count_r <= reload_value;
			end else begin
				count_r <= tpb_pkg::COUNT_FULL;
			end
		end else if (timer_tick && !oneshot_done_r && count_r != tpb_pkg::COUNT_ZERO) begin
			count_r <= count_r - tpb_pkg::COUNT_ONE;
		end
	end

	// One-shot stop latch, released by a count write or leaving one-shot
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			oneshot_done_r <= 1'b0;
		end else if (wr_count || !one_shot) begin
			oneshot_done_r <= 1'b0;
		end else if (underflow) begin
			oneshot_done_r <= 1'b1;
		end
	end

	// Sticky underflow flag, set wins over a write-one clear
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			flag_r <= 1'b0;
		end else if (underflow) begin
			flag_r <= 1'b1;
		end else if (i_wr && i_addr == tpb_pkg::OFS_TIMER_STATUS
				&& i_wdata[tpb_pkg::BIT_UNDERFLOW_FLAG]) begin
			flag_r <= 1'b0;
		end
	end

	// Buzzer source: prescaler tap or timer bit
	always_comb begin
		if (buzzer_frequency_select[3]) begin
			buzz_src = count_r[buzzer_frequency_select[2:0]];
		end else begin
			buzz_src = prescaler_r[buzzer_frequency_select[2:0]];
		end
	end

	// PWM is asserted while the count is below the duty value
	assign pwm_level = (count_r < duty_value) ^ pwm_active_low;

	// Registered pin outputs
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_pwm_port_pin   <= 1'b0;
			o_pwm_pin_enable <= 1'b0;
			o_buzzer         <= 1'b0;
		end else begin
			o_pwm_port_pin   <= pwm_level;
			o_pwm_pin_enable <= control_one_r[tpb_pkg::BIT_PWM_PIN_ENABLE];
			o_buzzer         <= buzzer_enable && buzz_src;
		end
	end

	assign o_timer_flag = flag_r;

	// Read data, valid in the cycle after the strobe
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_rdata <= tpb_pkg::RST_BYTE;
		end else if (i_rd) begin
			case (i_addr)
				tpb_pkg::OFS_COUNT_RELOAD:    o_rdata <= count_r[7:0];
				tpb_pkg::OFS_CONTROL_ONE:     o_rdata <= control_one_r;
				tpb_pkg::OFS_CONTROL_TWO:     o_rdata <= control_two_r;
				tpb_pkg::OFS_PRESCALER_VALUE: o_rdata <= prescaler_r;
				tpb_pkg::OFS_SHARED_HIGH:     o_rdata <= shared_high_r;
				tpb_pkg::OFS_TIMER_STATUS:    o_rdata <= {7'h00, flag_r};
				default:                      o_rdata <= tpb_pkg::RST_BYTE;
			endcase
		end else begin
			o_rdata <= tpb_pkg::RST_BYTE;
		end
	end

	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	sequence s_count_read;
		i_rd && i_addr == tpb_pkg::OFS_COUNT_RELOAD;
	endsequence

	property p_count_read;
		s_count_read |=> o_rdata == $past(count_r[7:0]);
	endproperty
	a_count_read: assert property (p_count_read)
		else $error("count read data wrong");

	property p_count_write;
		wr_count |=> count_r == {$past(shared_high_r[7:6]), $past(i_wdata)}
			&& reload_low_r == $past(i_wdata);
	endproperty
	a_count_write: assert property (p_count_write)
		else $error("count write did not load counter");

	property p_hold_when_off;
		(!run_enable && !wr_count) |=> $stable(count_r);
	endproperty
	a_hold_when_off: assert property (p_hold_when_off)
		else $error("counter moved while disabled");

	property p_wrap_full;
		(underflow && !one_shot && !auto_reload && !wr_count)
			|=> count_r == tpb_pkg::COUNT_FULL;
	endproperty
	a_wrap_full: assert property (p_wrap_full)
		else $error("underflow did not load full count");

	property p_wrap_reload;
		(underflow && !one_shot && auto_reload && !wr_count)
			|=> count_r == $past(reload_value);
	endproperty
	a_wrap_reload: assert property (p_wrap_reload)
		else $error("underflow did not load reload value");

	sequence s_oneshot_end;
		underflow && one_shot && !wr_count;
	endsequence

	property p_oneshot_stop;
		s_oneshot_end ##1 (one_shot && !wr_count) [*3] |-> count_r == tpb_pkg::COUNT_ZERO
			&& !underflow;
	endproperty
	a_oneshot_stop: assert property (p_oneshot_stop)
		else $error("one-shot timer kept counting");

	property p_pwm_polarity;
		##1 o_pwm_port_pin == (($past(count_r) < $past(duty_value)) ^ $past(pwm_active_low));
	endproperty
	a_pwm_polarity: assert property (p_pwm_polarity)
		else $error("pwm level or polarity wrong");

	property p_bypass_tick;
		(prescaler_enable_n && !clock_source_select && run_enable && !wr_count
			&& count_r > tpb_pkg::COUNT_ZERO) |=> count_r == $past(count_r) - tpb_pkg::COUNT_ONE;
	endproperty
	a_bypass_tick: assert property (p_bypass_tick)
		else $error("bypassed prescaler did not tick every cycle");

	property p_ext_edge;
		(clock_source_select && ext_clock_edge_select && !i_ext_clock_pin && ext_prev_r)
			|-> src_tick;
	endproperty
	a_ext_edge: assert property (p_ext_edge)
		else $error("falling edge not counted");

	property p_buzzer_off;
		!buzzer_enable |=> !o_buzzer;
	endproperty
	a_buzzer_off: assert property (p_buzzer_off)
		else $error("buzzer active while disabled");

	property p_flag_set;
		underflow |=> flag_r;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("underflow flag not set");

endmodule : tpb_timer

//--- logic/tpb_pkg.sv
package tpb_pkg;
	localparam int          ADDR_W              = 5;
	localparam int          DATA_W              = 8;
	// Register offsets
	localparam logic [4:0]  OFS_COUNT_RELOAD    = 5'h09;
	localparam logic [4:0]  OFS_CONTROL_ONE     = 5'h0A;
	localparam logic [4:0]  OFS_CONTROL_TWO     = 5'h0B;
	localparam logic [4:0]  OFS_DUTY_LOW        = 5'h0C;
	localparam logic [4:0]  OFS_PRESCALER_VALUE = 5'h0D;
	localparam logic [4:0]  OFS_BUZZER_CONTROL  = 5'h0E;
	localparam logic [4:0]  OFS_SHARED_HIGH     = 5'h1F;
	localparam logic [4:0]  OFS_TIMER_STATUS    = 5'h1E;
	// Control one fields
	localparam int          BIT_RUN_ENABLE      = 0;
	localparam int          BIT_AUTO_RELOAD     = 1;
	localparam int          BIT_ONE_SHOT        = 2;
	localparam int          BIT_PWM_ACTIVE_LOW  = 6;
	localparam int          BIT_PWM_PIN_ENABLE  = 7;
	// Control two fields
	localparam int          BIT_PRESCALE_LSB    = 0;
	localparam int          BIT_PRESCALER_EN_N  = 3;
	localparam int          BIT_EDGE_SELECT     = 4;
	localparam int          BIT_CLOCK_SOURCE    = 5;
	// Buzzer control fields
	localparam int          BIT_BUZZ_FREQ_LSB   = 0;
	localparam int          BIT_BUZZ_ENABLE     = 7;
	// Shared high bits fields
	localparam int          BIT_DUTY_HIGH_LSB   = 2;
	localparam int          BIT_RELOAD_HIGH_LSB = 6;
	// Status fields
	localparam int          BIT_UNDERFLOW_FLAG  = 0;
	// Reset values
	localparam logic [7:0]  RST_CONTROL_ONE     = 8'h00;
	localparam logic [7:0]  RST_CONTROL_TWO     = 8'h3F;
	localparam logic [7:0]  RST_BUZZER_CONTROL  = 8'h0F;
	localparam logic [7:0]  RST_PRESCALER       = 8'hFF;
	localparam logic [7:0]  RST_BYTE            = 8'h00;
	localparam logic [9:0]  RST_COUNT           = 10'h000;
	// Counter constants
	localparam logic [9:0]  COUNT_FULL          = 10'h3FF;
	localparam logic [9:0]  COUNT_ZERO          = 10'h000;
	localparam logic [9:0]  COUNT_ONE           = 10'h001;
	localparam logic [7:0]  PRE_ONE             = 8'h01;
endpackage : tpb_pkg

//--- sim/tpb_ext_clk_model.sv
`timescale 1ns/1ps
module tpb_ext_clk_model (
	input  wire logic i_clk_sys,
	output logic      o_ext_clock_pin
);
	// Pin rests low between bursts and stands still outside them
	initial begin
		o_ext_clock_pin = 1'b0;
	end

	// Sends n full pulses, each level held for hold cycles (one is the fastest legal rate)
	task automatic pulses(input int n, input int hold);
		repeat (n) begin
			repeat (hold) @(posedge i_clk_sys);
			o_ext_clock_pin <= 1'b1;
			repeat (hold) @(posedge i_clk_sys);
			o_ext_clock_pin <= 1'b0;
		end
	endtask : pulses
endmodule : tpb_ext_clk_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic                        i_clk_sys;
	logic                        i_reset;
	logic [tpb_pkg::ADDR_W-1:0]  i_addr;
	logic [tpb_pkg::DATA_W-1:0]  i_wdata;
	logic                        i_wr;
	logic                        i_rd;
	logic [tpb_pkg::DATA_W-1:0]  o_rdata;
	logic                        ext_pin;
	logic                        o_pwm_port_pin;
	logic                        o_pwm_pin_enable;
	logic                        o_buzzer;
	logic                        o_timer_flag;
	int                          mismatches;
	int                          tests_run;
	logic [7:0]                  cnt;

	tpb_timer dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_ext_clock_pin(ext_pin), .o_pwm_port_pin(o_pwm_port_pin),
		.o_pwm_pin_enable(o_pwm_pin_enable), .o_buzzer(o_buzzer),
		.o_timer_flag(o_timer_flag));
	tpb_ext_clk_model ext_u (.i_clk_sys(i_clk_sys), .o_ext_clock_pin(ext_pin));

	// 40 MHz system clock
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Write strobe stays up until the next bus call lowers or reuses it
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr    <= 1'b1;
		i_rd    <= 1'b0;
		i_addr  <= a;
		i_wdata <= d;
	endtask : wr

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge i_clk_sys);
			i_wr <= 1'b0;
			i_rd <= 1'b0;
		end
	endtask : idle

	// Read data is looked at in the one cycle after the strobe
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		@(posedge i_clk_sys);
		i_wr   <= 1'b0;
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		@(negedge i_clk_sys);
		check(o_rdata, exp);
	endtask : rd_chk

	// Lets registered pin outputs settle before they are sampled
	task automatic settle;
		idle(3);
		@(negedge i_clk_sys);
	endtask : settle

	// Runs the timer for n+1 ticks of the instruction clock, then stops it
	task automatic run_for(input logic [7:0] c1, input int n);
		wr(tpb_pkg::OFS_CONTROL_ONE, c1);
		idle(n);
		wr(tpb_pkg::OFS_CONTROL_ONE, c1 & 8'hFE);
	endtask : run_for

	// Cuts a hung run short
	initial begin
		repeat (100000) @(posedge i_clk_sys);
		mismatches++;
		end_sim();
	end

	initial begin
		mismatches = 0;
		tests_run  = 0;
		i_reset    = 1'b1;
		i_addr     = 5'h00;
		i_wdata    = 8'h00;
		i_wr       = 1'b0;
		i_rd       = 1'b0;
		repeat (16) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		// Reset values and read-only or write-only places
		rd_chk(tpb_pkg::OFS_CONTROL_ONE, 8'h00);
		rd_chk(tpb_pkg::OFS_CONTROL_TWO, 8'h3F);
		rd_chk(tpb_pkg::OFS_PRESCALER_VALUE, 8'hFF);
		wr(tpb_pkg::OFS_PRESCALER_VALUE, 8'h12);
		rd_chk(tpb_pkg::OFS_PRESCALER_VALUE, 8'hFF);
		rd_chk(tpb_pkg::OFS_BUZZER_CONTROL, 8'h00);
		rd_chk(5'h00, 8'h00);
		check({o_buzzer, o_timer_flag, o_pwm_pin_enable}, 8'h00);
		// Buzzer from timer bits, then from held prescaler taps
		cnt = 8'hA5;
		wr(tpb_pkg::OFS_SHARED_HIGH, 8'h00);
		wr(tpb_pkg::OFS_COUNT_RELOAD, cnt);
		for (int c = 8; c < 16; c++) begin
			wr(tpb_pkg::OFS_BUZZER_CONTROL, 8'h80 | 8'(c));
			settle();
			check({7'h00, o_buzzer}, {7'h00, cnt[c-8]});
		end
		for (int c = 0; c < 8; c++) begin
			wr(tpb_pkg::OFS_BUZZER_CONTROL, 8'h80 | 8'(c));
			settle();
			check({7'h00, o_buzzer}, 8'h01);
		end
		wr(tpb_pkg::OFS_BUZZER_CONTROL, 8'h0F);
		settle();
		check({7'h00, o_buzzer}, 8'h00);
		// Count write with reload high bits, internal clock, stop and hold
		wr(tpb_pkg::OFS_SHARED_HIGH, 8'h40);
		wr(tpb_pkg::OFS_COUNT_RELOAD, 8'h05);
		rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'h05);
		wr(tpb_pkg::OFS_CONTROL_TWO, 8'h08);
		run_for(8'h01, 9);
		rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'hFB);
		idle(5);
		rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'hFB);
		check({7'h00, o_timer_flag}, 8'h00);
		// Underflow without reload, flag set then cleared
		wr(tpb_pkg::OFS_SHARED_HIGH, 8'h00);
		wr(tpb_pkg::OFS_COUNT_RELOAD, 8'h02);
		run_for(8'h01, 2);
		rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'hFF);
		check({7'h00, o_timer_flag}, 8'h01);
		wr(tpb_pkg::OFS_TIMER_STATUS, 8'h01);
		settle();
		check({7'h00, o_timer_flag}, 8'h00);
		// Underflow with reload, then one-shot with reload bit also set
		wr(tpb_pkg::OFS_COUNT_RELOAD, 8'h03);
		run_for(8'h03, 5);
		rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'h01);
		wr(tpb_pkg::OFS_COUNT_RELOAD, 8'h02);
		wr(tpb_pkg::OFS_CONTROL_ONE, 8'h07);
		idle(10);
		rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'h00);
		wr(tpb_pkg::OFS_CONTROL_ONE, 8'h00);
		// External clock: falling edges, slow pulses; then rising edges, fast pulses
		wr(tpb_pkg::OFS_CONTROL_TWO, 8'h38);
		wr(tpb_pkg::OFS_COUNT_RELOAD, 8'h10);
		wr(tpb_pkg::OFS_CONTROL_ONE, 8'h01);
		idle(2);
		ext_u.pulses(4, 3);
		run_for(8'h01, 3);
		rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'h0C);
		wr(tpb_pkg::OFS_CONTROL_TWO, 8'h28);
		wr(tpb_pkg::OFS_COUNT_RELOAD, 8'h10);
		wr(tpb_pkg::OFS_CONTROL_ONE, 8'h01);
		idle(2);
		ext_u.pulses(3, 1);
		run_for(8'h01, 3);
		rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'h0D);
		// Every ratio: two timer ticks per window of twice the division
		for (int r = 0; r < 8; r++) begin
			wr(tpb_pkg::OFS_CONTROL_TWO, 8'h08 | 8'(r));
			wr(tpb_pkg::OFS_CONTROL_TWO, 8'(r));
			wr(tpb_pkg::OFS_COUNT_RELOAD, 8'h10);
			run_for(8'h01, (4 << r) - 1);
			rd_chk(tpb_pkg::OFS_COUNT_RELOAD, 8'h0E);
			wr(tpb_pkg::OFS_CONTROL_TWO, 8'h08 | 8'(r));
		end
		// PWM level against duty, polarity and pin hand-over
		wr(tpb_pkg::OFS_COUNT_RELOAD, 8'h10);
		wr(tpb_pkg::OFS_DUTY_LOW, 8'h20);
		wr(tpb_pkg::OFS_CONTROL_ONE, 8'h80);
		settle();
		check({o_pwm_pin_enable, o_pwm_port_pin}, 8'h03);
		wr(tpb_pkg::OFS_CONTROL_ONE, 8'hC0);
		settle();
		check({7'h00, o_pwm_port_pin}, 8'h00);
		wr(tpb_pkg::OFS_DUTY_LOW, 8'h08);
		settle();
		check({7'h00, o_pwm_port_pin}, 8'h01);
		wr(tpb_pkg::OFS_SHARED_HIGH, 8'h04);
		settle();
		check({7'h00, o_pwm_port_pin}, 8'h00);
		wr(tpb_pkg::OFS_CONTROL_ONE, 8'h00);
		settle();
		check({7'h00, o_pwm_pin_enable}, 8'h00);
		end_sim();
	end
endmodule : tb_top
